// ===== ota_alert.sv
// Top of the over-temperature alert logic: AHB-Lite registers, status and alert pins.
`timescale 1ns/1ps
module ota_alert #(
    parameter int         ADDR_W   = 32,
    parameter logic [7:0] PART_ID  = 8'h5A, // Arbitrary identity value.
    parameter logic [7:0] MAKER_ID = 8'hA5  // Arbitrary identity value.
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic      [31:0]       hrdata,
    output logic                   hresp,
    input  wire logic [7:0]        local_temp_i,
    input  wire logic [7:0]        remote_temp_i,
    input  wire logic              remote_fault_i,
    input  wire logic              fan_slow_i,
    input  wire logic              fan_fast_i,
    input  wire logic              therm_in_i,
    input  wire logic              passive_i,
    output logic                   overtemp_out_n_o,
    output logic                   overtemp_out_n_oe,
    output logic                   smbalert_n_o,
    output logic                   smbalert_n_oe
);
    import ota_pkg::*;

    if (ADDR_W < 11) begin : g_chk
        $error("ota_alert needs at least 11 address bits");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;

        logic [7:0] lhi;
        logic [7:0] llo;
        logic [7:0] lthm;
        logic [7:0] rhi;
        logic [7:0] rlo;
        logic [7:0] rthm;
        logic [7:0] lcrit;
        logic [7:0] rcrit;

        logic       srst;
        logic       wr_pend;
        logic [7:0] wr_idx;
        logic [7:0] rdata;

        logic       rdy;
        logic       ovr_oe;
        logic       alert_oe;
    } ota_state_t;

    localparam ota_state_t RST_S = '{
        cfg1:     RST_CFG1,
        cfg2:     RST_CFG2,
        cfg3:     RST_CFG3,
        cfg4:     RST_CFG4,

        lhi:      RST_LHI,
        llo:      RST_LLO,
        lthm:     RST_LTHM,
        rhi:      RST_RHI,
        rlo:      RST_RLO,
        rthm:     RST_RTHM,
        lcrit:    RST_LCRIT,
        rcrit:    RST_RCRIT,

        srst:     1'b0,
        wr_pend:  1'b0,
        wr_idx:   8'h00,
        rdata:    8'h00,

        rdy:      1'b1,
        ovr_oe:   1'b0,
        alert_oe: 1'b0
    };

    ota_state_t q;
    ota_state_t d;

    logic [15:0] cond;
    logic [15:0] lane_clr;
    logic [15:0] sticky;
    logic [15:0] pend;
    logic [15:0] irq_en;

    logic [7:0]  stat1;
    logic [7:0]  stat2;

    logic [7:0]  aidx;
    logic        amap;
    logic        rd_acc;
    logic        wr_acc;
    logic        clr1;
    logic        clr2;

    logic        lflag;
    logic        rflag;

    logic        lhold;
    logic        rhold;
    logic        remote_sensor_fail_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase decode.

    always_comb begin
        aidx   = haddr[9:2];
        amap   = (haddr[ADDR_W-1:10] == '0) && (haddr[1:0] == 2'h0);

        rd_acc = hsel && hready && htrans[1] && !hwrite && amap;
        wr_acc = hsel && hready && htrans[1] && hwrite && amap;

        clr1   = rd_acc && (aidx == IDX_STAT1);
        clr2   = rd_acc && (aidx == IDX_STAT2);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status sources.

    always_comb begin
        cond         = '0;
        cond[S_LTL]  = !ota_ge(local_temp_i, q.llo);
        cond[S_LTH]  = !ota_ge(q.lhi, local_temp_i);
        cond[S_RTF]  = remote_fault_i;
        cond[S_RTHM] = ota_ge(remote_temp_i, q.rthm);
        cond[S_RTL]  = !ota_ge(remote_temp_i, q.rlo);
        cond[S_RTH]  = !ota_ge(q.rhi, remote_temp_i);
        cond[S_FANS] = fan_slow_i;
        cond[S_RPM]  = fan_fast_i;
        cond[S_THIN] = therm_in_i;
        cond[S_LTHM] = ota_ge(local_temp_i, q.lthm);
        cond[S_LPSV] = passive_i;

        lane_clr     = {{8{clr2}}, {8{clr1}}};

        // The sensor failure lane is never cleared by a read, only by a reset.
        lane_clr[S_RTF] = 1'b0;
    end

    ota_sticky #(
        .W (16)
    ) u_sticky (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .soft_rst (q.srst),
        .cond     (cond),
        .rd_clr   (lane_clr),
        .flags    (sticky)
    );

    ota_crit_chan u_local_crit (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .soft_rst (q.srst),
        .temp     (local_temp_i),
        .limit    (q.lcrit),
        .rd_clr   (clr2),
        .flag     (lflag),
        .hold     (lhold)
    );

    ota_crit_chan u_remote_crit (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .soft_rst (q.srst),
        .temp     (remote_temp_i),
        .limit    (q.rcrit),
        .rd_clr   (clr2),
        .flag     (rflag),
        .hold     (rhold)
    );

    always_comb begin
        remote_sensor_fail_flag          = sticky[S_RTF];

        pend         = sticky;
        pend[S_LTC]  = lflag;
        pend[S_RTC]  = rflag;
        stat1        = pend[7:0];
        // Lanes below the critical flags are reserved and always read zero.
        stat2        = {pend[15:11], 3'h0};

        irq_en         = '0;
        irq_en[S_LTL]  = q.cfg2[C2_LLIM_IE];
        irq_en[S_LTH]  = q.cfg2[C2_LLIM_IE];
        irq_en[S_LTHM] = q.cfg2[C2_LLIM_IE];
        irq_en[S_LTC]  = q.cfg2[C2_LLIM_IE];
        irq_en[S_RTL]  = q.cfg2[C2_RLIM_IE];
        irq_en[S_RTH]  = q.cfg2[C2_RLIM_IE];
        irq_en[S_RTHM] = q.cfg2[C2_RLIM_IE];
        irq_en[S_RTC]  = q.cfg2[C2_RLIM_IE];
        irq_en[S_RTF]  = q.cfg2[C2_RFAIL_IE];
        irq_en[S_FANS] = q.cfg1[C1_FAN_IE];
        irq_en[S_RPM]  = q.cfg1[C1_FAN_IE];
        irq_en[S_LPSV] = q.cfg2[C2_PSV_IE];
        irq_en[S_THIN] = q.cfg1[C1_THERM_IE];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file, bus answers and pins.

    always_comb begin
        d = q;
        d.rdy     = 1'b1;
        d.wr_pend = wr_acc;
        d.srst    = 1'b0;

        if (wr_acc) begin
            d.wr_idx = aidx;
        end

        // Read data is sampled in the address phase so the slave never waits.
        if (rd_acc) begin
            if (aidx == IDX_CFG1) begin
                d.rdata = q.cfg1;
            end else if (aidx == IDX_CFG2) begin
                d.rdata = q.cfg2;
            end else if (aidx == IDX_STAT1) begin
                d.rdata = stat1;
            end else if (aidx == IDX_STAT2) begin
                d.rdata = stat2;
            end else if (aidx == IDX_CFG4) begin
                d.rdata = q.cfg4;
            end else if (aidx == IDX_LHI) begin
                d.rdata = q.lhi;
            end else if (aidx == IDX_LLO) begin
                d.rdata = q.llo;
            end else if (aidx == IDX_LTHM) begin
                d.rdata = q.lthm;
            end else if (aidx == IDX_RHI) begin
                d.rdata = q.rhi;
            end else if (aidx == IDX_RLO) begin
                d.rdata = q.rlo;
            end else if (aidx == IDX_RTHM) begin
                d.rdata = q.rthm;
            end else if (aidx == IDX_LCRIT) begin
                d.rdata = q.lcrit;
            end else if (aidx == IDX_RCRIT) begin
                d.rdata = q.rcrit;
            end else if (aidx == IDX_PART) begin
                d.rdata = PART_ID;
            end else if (aidx == IDX_MAKER) begin
                d.rdata = MAKER_ID;
            end else if (aidx == IDX_CFG3) begin
                d.rdata = q.cfg3;
            end else begin
                d.rdata = 8'h00;
            end
        end else if (hsel && hready && htrans[1]) begin
            d.rdata = 8'h00;
        end

        // Writes land in the data phase; status, identity and reserved words ignore them.
        if (q.wr_pend) begin
            if (q.wr_idx == IDX_CFG1) begin
                d.cfg1 = hwdata[7:0];
            end else if (q.wr_idx == IDX_CFG2) begin
                d.cfg2 = hwdata[7:0];
                d.srst = hwdata[C2_SRST];
            end else if (q.wr_idx == IDX_CFG4) begin
                d.cfg4 = hwdata[7:0];
            end else if (q.wr_idx == IDX_LHI) begin
                d.lhi = hwdata[7:0];
            end else if (q.wr_idx == IDX_LLO) begin
                d.llo = hwdata[7:0];
            end else if (q.wr_idx == IDX_LTHM) begin
                d.lthm = hwdata[7:0];
            end else if (q.wr_idx == IDX_RHI) begin
                d.rhi = hwdata[7:0];
            end else if (q.wr_idx == IDX_RLO) begin
                d.rlo = hwdata[7:0];
            end else if (q.wr_idx == IDX_RTHM) begin
                d.rthm = hwdata[7:0];
            end else if (q.wr_idx == IDX_LCRIT) begin
                d.lcrit = hwdata[7:0];
            end else if (q.wr_idx == IDX_RCRIT) begin
                d.rcrit = hwdata[7:0];
            end else if (q.wr_idx == IDX_CFG3) begin
                d.cfg3 = (hwdata[7:0] & CFG3_WR_MASK) | (q.cfg3 & ~CFG3_WR_MASK);
            end
        end

        // Pin drive uses the hold bits and the fault flag as they stand; masking gates only the alert.
        d.ovr_oe   = q.cfg4[C4_OVERTEMP_PIN_ENABLE] && (lhold || rhold || remote_sensor_fail_flag);
        d.alert_oe = q.cfg1[C1_GIE] && ((pend & irq_en) != '0);

        // The software reset bit never reads back as one: the whole state restarts.
        if (q.srst) begin
            d = RST_S;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RST_S;
        end else begin
            q <= d;
        end
    end

    assign hreadyout         = q.rdy;
    assign hrdata            = {24'h000000, q.rdata};
    assign hresp             = 1'b0;

    assign overtemp_out_n_o  = 1'b0;
    assign overtemp_out_n_oe = q.ovr_oe;
    assign smbalert_n_o      = 1'b0;
    assign smbalert_n_oe     = q.alert_oe;

endmodule : ota_alert

// ===== ota_alert_chk.sv
// Concurrent checks on the ports of the over-temperature alert top.
`timescale 1ns/1ps
module ota_alert_chk #(
    parameter int ADDR_W = 32
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic [31:0]       hrdata,
    input wire logic              hresp,
    input wire logic [7:0]        local_temp_i,
    input wire logic [7:0]        remote_temp_i,
    input wire logic              remote_fault_i,
    input wire logic              fan_slow_i,
    input wire logic              fan_fast_i,
    input wire logic              therm_in_i,
    input wire logic              passive_i,
    input wire logic              overtemp_out_n_o,
    input wire logic              overtemp_out_n_oe,
    input wire logic              smbalert_n_o,
    input wire logic              smbalert_n_oe
);
    import ota_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Register bits the pins depend on, snooped off the bus.
    logic       wr_q, res_q, fail_q, overtemp_pin_enable_q, gie_q, rfie_q;
    logic [7:0] idx_q, lcrit_q, rcrit_q;
    wire  [7:0] aidx = haddr[9:2];
    wire        take = hsel && hready && htrans[1];
    wire        mapped = haddr[1:0] == 2'h0 && haddr[ADDR_W-1:10] == '0 && aidx inside {
        IDX_CFG1, IDX_CFG2, IDX_STAT1, IDX_STAT2, IDX_CFG4, IDX_LHI, IDX_LLO, IDX_LTHM,
        IDX_RHI, IDX_RLO, IDX_RTHM, IDX_LCRIT, IDX_RCRIT, IDX_PART, IDX_MAKER, IDX_CFG3};
    wire        hot = $signed(local_temp_i) >= $signed(lcrit_q)
                   || $signed(remote_temp_i) >= $signed(rcrit_q);
    wire        cool = $signed({local_temp_i[7], local_temp_i}) <= $signed({lcrit_q[7], lcrit_q})
                   - HYST_C && $signed({remote_temp_i[7], remote_temp_i})
                   <= $signed({rcrit_q[7], rcrit_q}) - HYST_C;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_q, res_q, idx_q} <= '0;
            {fail_q, overtemp_pin_enable_q, gie_q, rfie_q} <= {1'b0, RST_CFG4[C4_OVERTEMP_PIN_ENABLE], RST_CFG1[C1_GIE],
                                                 RST_CFG2[C2_RFAIL_IE]};
            {lcrit_q, rcrit_q} <= {RST_LCRIT, RST_RCRIT};
        end else begin
            wr_q <= take && hwrite && mapped;
            res_q <= take && !hwrite && !mapped;
            idx_q <= aidx;
            if (remote_fault_i) fail_q <= 1'b1;
            if (wr_q && idx_q == IDX_CFG2 && hwdata[C2_SRST]) begin
                {fail_q, overtemp_pin_enable_q, gie_q, rfie_q} <= {1'b0, RST_CFG4[C4_OVERTEMP_PIN_ENABLE],
                                                     RST_CFG1[C1_GIE], RST_CFG2[C2_RFAIL_IE]};
                {lcrit_q, rcrit_q} <= {RST_LCRIT, RST_RCRIT};
            end else if (wr_q) begin
                if (idx_q == IDX_CFG1) gie_q <= hwdata[C1_GIE];
                if (idx_q == IDX_CFG2) rfie_q <= hwdata[C2_RFAIL_IE];
                if (idx_q == IDX_CFG4) overtemp_pin_enable_q <= hwdata[C4_OVERTEMP_PIN_ENABLE];
                if (idx_q == IDX_LCRIT) lcrit_q <= hwdata[7:0];
                if (idx_q == IDX_RCRIT) rcrit_q <= hwdata[7:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_hot_armed;
        hot && overtemp_pin_enable_q ##1 overtemp_pin_enable_q;
    endsequence
    sequence s_fault_armed;
        remote_fault_i && overtemp_pin_enable_q ##1 overtemp_pin_enable_q;
    endsequence
    property p_ovr_hiz;
        !overtemp_pin_enable_q && !$past(overtemp_pin_enable_q) && !$past(overtemp_pin_enable_q, 2) |-> !overtemp_out_n_oe;
    endproperty
    property p_ovr_low;
        overtemp_out_n_oe |-> !overtemp_out_n_o;
    endproperty
    property p_ovr_set;
        s_hot_armed |=> overtemp_out_n_oe;
    endproperty
    property p_ovr_release;
        (cool && !fail_q) [*4] |-> !overtemp_out_n_oe;
    endproperty
    property p_fail_force;
        s_fault_armed |=> overtemp_out_n_oe;
    endproperty
    property p_fail_hold;
        $past(fail_q) && overtemp_pin_enable_q && $past(overtemp_pin_enable_q) |-> overtemp_out_n_oe;
    endproperty
    property p_fail_alert;
        $past(fail_q) && gie_q && rfie_q && $past(gie_q && rfie_q) |-> smbalert_n_oe;
    endproperty
    property p_alert_low;
        smbalert_n_oe |-> !smbalert_n_o;
    endproperty
    property p_byte_wide;
        hrdata[31:8] == 24'h0;
    endproperty
    property p_res_zero;
        res_q |-> hrdata == 32'h0;
    endproperty
    a_ovr_hiz: assert property (p_ovr_hiz) else $error("pin driven while off");
    a_ovr_low: assert property (p_ovr_low) else $error("over-temp pin driven high");
    a_ovr_set: assert property (p_ovr_set) else $error("pin not low at limit");
    a_ovr_release: assert property (p_ovr_release) else $error("over-temp pin held");
    a_fail_force: assert property (p_fail_force) else $error("sensor fault not on pin");
    a_fail_hold: assert property (p_fail_hold) else $error("fault pin released");
    a_fail_alert: assert property (p_fail_alert) else $error("fault alert missing");
    a_alert_low: assert property (p_alert_low) else $error("alert pin driven high");
    a_byte_wide: assert property (p_byte_wide) else $error("upper read data not zero");
    a_res_zero: assert property (p_res_zero) else $error("reserved read not zero");
endmodule : ota_alert_chk

bind ota_alert ota_alert_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// ===== ota_crit_chan.sv
// One over-critical channel: clear-on-read flag with re-arm and the pin hold.
`timescale 1ns/1ps
module ota_crit_chan (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       soft_rst,
    input  wire logic [7:0] temp,
    input  wire logic [7:0] limit,
    input  wire logic       rd_clr,
    output logic            flag,
    output logic            hold
);
    import ota_pkg::*;

    typedef struct packed {
        logic flag;
        logic armed;
        logic hold;
    } ota_crit_t;

    localparam ota_crit_t RST_S = '{flag: 1'b0, armed: 1'b1, hold: 1'b0};

    ota_crit_t q;
    ota_crit_t d;
    logic      above;
    logic      below;

    always_comb begin
        above = ota_ge(temp, limit);
        below = ota_below(temp, limit);
        d = q;
        if (rd_clr) begin
            d.flag = 1'b0;
        end
        // Once set, the flag stays disarmed until the reading drops clear of the limit.
        if (below) begin
            d.armed = 1'b1;
        end
        if (above && q.armed) begin
            d.flag  = 1'b1;
            d.armed = 1'b0;
        end
        if (above) begin
            d.hold = 1'b1;
        end else if (below) begin
            d.hold = 1'b0;
        end
        if (soft_rst) begin
            d = RST_S;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RST_S;
        end else begin
            q <= d;
        end
    end

    assign flag = q.flag;
    assign hold = q.hold;

endmodule : ota_crit_chan

// ===== ota_host_mdl.sv
// Host side of the alarm pins: pull-ups on both open-drain lines.
`timescale 1ns/1ps
module ota_host_mdl (
    input  wire logic overtemp_out_n_o,
    input  wire logic overtemp_out_n_oe,
    input  wire logic smbalert_n_o,
    input  wire logic smbalert_n_oe,
    output logic      overtemp_pin,
    output logic      smbalert_pin
);
    // A released line floats to the pull-up level, never to the last driven value.
    assign overtemp_pin = overtemp_out_n_oe ? overtemp_out_n_o : 1'b1;
    assign smbalert_pin = smbalert_n_oe ? smbalert_n_o : 1'b1;
endmodule : ota_host_mdl

// ===== ota_pkg.sv
// Shared constants, register map and helper functions of the over-temperature alert logic.
package ota_pkg;

    localparam int REG_W = 8;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CFG1  = 8'h00;
    localparam logic [7:0] IDX_CFG2  = 8'h01;
    localparam logic [7:0] IDX_STAT1 = 8'h02;
    localparam logic [7:0] IDX_STAT2 = 8'h03;
    localparam logic [7:0] IDX_CFG4  = 8'h04;
    localparam logic [7:0] IDX_LHI   = 8'h14;
    localparam logic [7:0] IDX_LLO   = 8'h15;
    localparam logic [7:0] IDX_LTHM  = 8'h16;
    localparam logic [7:0] IDX_RHI   = 8'h18;
    localparam logic [7:0] IDX_RLO   = 8'h19;
    localparam logic [7:0] IDX_RTHM  = 8'h1A;
    localparam logic [7:0] IDX_LCRIT = 8'h1B;
    localparam logic [7:0] IDX_RCRIT = 8'h1D;
    localparam logic [7:0] IDX_PART  = 8'h3D;
    localparam logic [7:0] IDX_MAKER = 8'h3E;
    localparam logic [7:0] IDX_CFG3  = 8'h3F;

    // Reset values.
    localparam logic [7:0] RST_CFG1  = 8'hD4;
    localparam logic [7:0] RST_CFG2  = 8'h3D;
    localparam logic [7:0] RST_CFG3  = 8'h82;
    localparam logic [7:0] RST_CFG4  = 8'h08;
    localparam logic [7:0] RST_LHI   = 8'h3C;
    localparam logic [7:0] RST_LLO   = 8'h00;
    localparam logic [7:0] RST_LTHM  = 8'h46;
    localparam logic [7:0] RST_RHI   = 8'h50;
    localparam logic [7:0] RST_RLO   = 8'h00;
    localparam logic [7:0] RST_RTHM  = 8'h64;
    localparam logic [7:0] RST_LCRIT = 8'h50;
    localparam logic [7:0] RST_RCRIT = 8'h55;

    // Writable bits of the third configuration register; the rest is revision.
    localparam logic [7:0] CFG3_WR_MASK = 8'h80;

    // Configuration bit positions.
    localparam int C1_THERM_IE = 7;
    localparam int C1_FAN_IE   = 2;
    localparam int C1_GIE      = 1;
    localparam int C2_SRST     = 7;
    localparam int C2_PSV_IE   = 6;
    localparam int C2_RLIM_IE  = 5;
    localparam int C2_LLIM_IE  = 4;
    localparam int C2_RFAIL_IE = 3;
    localparam int C4_OVERTEMP_PIN_ENABLE    = 4;

    // Status lanes: 7..0 first status register, 15..8 second status register.
    localparam int S_LTL  = 7;
    localparam int S_LTH  = 6;
    localparam int S_RTF  = 5;
    localparam int S_RTHM = 4;
    localparam int S_RTL  = 3;
    localparam int S_RTH  = 2;
    localparam int S_FANS = 1;
    localparam int S_RPM  = 0;
    localparam int S_THIN = 15;
    localparam int S_LTHM = 14;
    localparam int S_LPSV = 13;
    localparam int S_LTC  = 12;
    localparam int S_RTC  = 11;

    // Re-arm and release hysteresis in degrees Celsius, one unit per degree.
    localparam logic signed [8:0] HYST_C = 9'sh005;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Signed greater-or-equal of two 8-bit temperatures.
    function automatic logic ota_ge(input logic [7:0] a, input logic [7:0] b);
        ota_ge = $signed(a) >= $signed(b);
    endfunction : ota_ge

    // True when a temperature sits at least the hysteresis below a limit.
    function automatic logic ota_below(input logic [7:0] t, input logic [7:0] lim);
        logic signed [8:0] thr;
        thr = $signed({lim[7], lim}) - HYST_C;
        ota_below = $signed({t[7], t}) <= thr;
    endfunction : ota_below

endpackage : ota_pkg

// ===== ota_sticky.sv
// Bank of sticky status flags that clear on read once their cause has gone.
`timescale 1ns/1ps
module ota_sticky #(
    parameter int W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         soft_rst,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] rd_clr,
    output logic      [W-1:0] flags
);
    import ota_pkg::*;

    if (W < 1) begin : g_chk
        $error("ota_sticky needs at least one lane");
    end

    typedef struct packed {
        logic [W-1:0] flag;
    } ota_stk_t;

    ota_stk_t q;
    ota_stk_t d;

    // A lane holds while its cause lasts, so a read during the excursion does not lose it.
    always_comb begin
        d = q;
        d.flag = cond | (q.flag & ~rd_clr);
        if (soft_rst) begin
            d.flag = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flags = q.flag;

endmodule : ota_sticky

// ===== test_ota_alert.sv
// Register-level bench of the over-temperature alert logic.
`timescale 1ns/1ps
module test_ota_alert;
    import ota_pkg::*;
    localparam logic [7:0] T_PART  = 8'h6E; // Arbitrary identity value.
    localparam logic [7:0] T_MAKER = 8'h91; // Arbitrary identity value.
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  local_temp_i, remote_temp_i, rv;
    logic        remote_fault_i, fan_slow_i, fan_fast_i, therm_in_i, passive_i;
    logic        overtemp_out_n_o, overtemp_out_n_oe, smbalert_n_o, smbalert_n_oe;
    logic        overtemp_pin, smbalert_pin;
    wire logic   hready = hreadyout;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [7:0]  tab_idx [16] = '{IDX_CFG1, IDX_CFG2, IDX_STAT1, IDX_STAT2, IDX_CFG4, IDX_LHI,
        IDX_LLO, IDX_LTHM, IDX_RHI, IDX_RLO, IDX_RTHM, IDX_LCRIT, IDX_RCRIT, IDX_PART,
        IDX_MAKER, IDX_CFG3};
    logic [7:0]  tab_val [16] = '{RST_CFG1, RST_CFG2, 8'h00, 8'h00, RST_CFG4, RST_LHI,
        RST_LLO, RST_LTHM, RST_RHI, RST_RLO, RST_RTHM, RST_LCRIT, RST_RCRIT, T_PART,
        T_MAKER, RST_CFG3};

    ota_alert #(.PART_ID(T_PART), .MAKER_ID(T_MAKER)) i_dut (.*);
    ota_host_mdl i_host (.*);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic pchk(input logic seen, input logic exp);
        chk({7'h0, seen}, {7'h0, exp});
    endtask : pchk

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic wait_ready();
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : wait_ready

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rv = hrdata[7:0];
    endtask : xfer

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rv, exp);
    endtask : rdc

    task automatic temps(input logic [7:0] lt, input logic [7:0] rt);
        local_temp_i <= lt;
        remote_temp_i <= rt;
        cyc(3);
    endtask : temps

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        {remote_fault_i, fan_slow_i, fan_fast_i, therm_in_i, passive_i} = '0;
        local_temp_i = 8'h20;
        remote_temp_i = 8'h20;
        cyc(2);
        hresetn <= 1'b1;
        foreach (tab_idx[i]) rdc(tab_idx[i], tab_val[i]);
        pchk(overtemp_out_n_oe, 1'b0);
        xfer(1'b1, 8'h05, 8'hFF);
        rdc(8'h05, 8'h00);
        xfer(1'b1, IDX_STAT1, 8'hFF);
        xfer(1'b1, IDX_PART, 8'h00);
        xfer(1'b1, IDX_CFG3, 8'h00);
        rdc(IDX_STAT1, 8'h00);
        rdc(IDX_PART, T_PART);
        rdc(IDX_CFG3, RST_CFG3 & ~CFG3_WR_MASK);
        xfer(1'b1, IDX_CFG1, 8'hD2);
        fan_slow_i <= 1'b1;
        cyc(3);
        fan_slow_i <= 1'b0;
        cyc(3);
        pchk(smbalert_pin, 1'b1);
        rdc(IDX_STAT1, 8'h02);
        rdc(IDX_STAT1, 8'h00);
        xfer(1'b1, IDX_CFG1, 8'hD6);
        fan_fast_i <= 1'b1;
        cyc(3);
        pchk(smbalert_pin, 1'b0);
        rdc(IDX_STAT1, 8'h01);
        xfer(1'b1, IDX_CFG1, 8'hD2);
        cyc(3);
        pchk(smbalert_pin, 1'b1);
        rdc(IDX_STAT1, 8'h01);
        fan_fast_i <= 1'b0;
        cyc(2);
        rdc(IDX_STAT1, 8'h01);
        rdc(IDX_STAT1, 8'h00);
        xfer(1'b1, IDX_CFG1, 8'hD6);
        cyc(3);
        pchk(smbalert_pin, 1'b1);
        fan_slow_i <= 1'b1;
        cyc(2);
        fan_slow_i <= 1'b0;
        cyc(6);
        pchk(smbalert_pin, 1'b0);
        rdc(IDX_STAT1, 8'h02);
        cyc(3);
        pchk(smbalert_pin, 1'b1);
        xfer(1'b1, IDX_CFG4, 8'h18);
        temps(RST_LCRIT, RST_RCRIT);
        pchk(overtemp_pin, 1'b0);
        rdc(IDX_STAT2, 8'h58);
        rdc(IDX_STAT2, 8'h40);
        temps(RST_LCRIT - 8'h04, RST_RCRIT - 8'h04);
        pchk(overtemp_pin, 1'b0);
        temps(RST_LCRIT - 8'h05, RST_RCRIT - 8'h05);
        pchk(overtemp_pin, 1'b1);
        rdc(IDX_STAT2, 8'h40);
        temps(RST_LCRIT, RST_RCRIT - 8'h05);
        rdc(IDX_STAT2, 8'h50);
        xfer(1'b1, IDX_CFG4, 8'h08);
        cyc(3);
        pchk(overtemp_out_n_oe, 1'b0);
        temps(8'h20, 8'h20);
        xfer(1'b0, IDX_STAT1, 8'h00);
        xfer(1'b0, IDX_STAT2, 8'h00);
        xfer(1'b1, IDX_CFG4, 8'h18);
        xfer(1'b1, IDX_CFG2, 8'h35);
        remote_fault_i <= 1'b1;
        cyc(2);
        remote_fault_i <= 1'b0;
        cyc(3);
        pchk(overtemp_pin, 1'b0);
        pchk(smbalert_pin, 1'b1);
        rdc(IDX_STAT1, 8'h20);
        rdc(IDX_STAT1, 8'h20);
        cyc(20);
        pchk(overtemp_pin, 1'b0);
        xfer(1'b1, IDX_CFG2, 8'h3D);
        cyc(3);
        pchk(smbalert_pin, 1'b0);
        xfer(1'b1, IDX_CFG2, 8'hBD);
        cyc(3);
        pchk(overtemp_out_n_oe, 1'b0);
        rdc(IDX_STAT1, 8'h00);
        rdc(IDX_CFG2, RST_CFG2);
        rdc(IDX_CFG1, RST_CFG1);
        end_of_test();
    end
endmodule : test_ota_alert
